// [cmpv_consts.svh]
// constant definitions for the chip mode, power and vector block
// Overview of operation
// RULE_01 - boot select one normal, zero special
// RULE_02 - capture boot select at reset release
// RULE_03 - mode bit readable, limited software changes
// RULE_04 - normal mode fetches via reset vector
// RULE_05 - special mode activates background debug monitor
// RULE_06 - stop instruction enters stop mode
// RULE_07 - reset, companion or unmasked irq exits stop
// RULE_08 - wait instruction halts cpu clock
// RULE_09 - peripherals keep running in wait
// RULE_10 - reset, companion or unmasked irq ends wait
// RULE_11 - watchdog and periodic freeze under debug
// RULE_12 - fixed priority, vector base plus offset
// RULE_13 - fixed reset vectors fffe fffc fffa
// RULE_14 - trap f8, software interrupt f6
// RULE_15 - link error f4 x, external f2 i
// RULE_16 - periodic f0, serial d8, lock c6, flash b8
// RULE_17 - spurious vector 80 when none remains
// RULE_18 - sixteen-bit vectors two bytes apart
// RULE_19 - reset gives defined start-up states
// RULE_20 - ram untouched by reset
// RULE_21 - highest offset wins among pending
`ifndef CMPV_CONSTS_SVH
`define CMPV_CONSTS_SVH
`define CMPV_MODE_NORMAL 1'b1
`define CMPV_MODE_SPECIAL 1'b0
`define CMPV_VEC_SYS 16'hfffe
`define CMPV_VEC_OSC 16'hfffc
`define CMPV_VEC_WDOG 16'hfffa
`define CMPV_OFS_TRAP 8'hf8
`define CMPV_OFS_SWI 8'hf6
`define CMPV_OFS_LNK 8'hf4
`define CMPV_OFS_LNKX 8'hf2
`define CMPV_OFS_PER 8'hf0
`define CMPV_OFS_SER 8'hd8
`define CMPV_OFS_LOCK 8'hc6
`define CMPV_OFS_FLASH 8'hb8
`define CMPV_OFS_SPUR 8'h80
`define CMPV_VBR_RESET 8'hff
`define CMPV_NSRC 9
`endif

// [cmpv_pkg.sv]
// types for the chip mode, power and vector block
package cmpv_pkg;
   typedef enum logic [2:0] {
      CMPV_RUN = 3'b001,
      CMPV_WAIT = 3'b010,
      CMPV_STOP = 3'b100
   } cmpv_pwr_e;
   // interrupt sources in priority order, bit 0 highest
   typedef struct packed {
      logic flash;
      logic lock;
      logic serial;
      logic periodic;
      logic link_ext;
      logic link_err;
      logic software_interrupt;
      logic trap;
   } cmpv_irq_s;
   typedef struct packed {
      logic sys;
      logic osc;
      logic wdog;
   } cmpv_rst_s;
endpackage

// [cmpv_top.sv]
// chip mode latch, low-power control and vector selection
`timescale 1ns/10ps
`default_nettype none
`include "cmpv_consts.svh"
module cmpv_top
   import cmpv_pkg::*;
#(
   parameter int VEC_W = 16
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // mode strap and software mode switching
   input wire logic boot_mode_select_i,
   input wire logic mode_wr_i,
   input wire logic mode_wdata_i,
   output logic mode_o,
   output logic background_debug_module_o,
   output logic fetch_internal_o,
   // cpu power requests
   input wire logic stop_instr_i,
   input wire logic wait_instruction_i,
   input wire logic companion_die_interrupt_i,
   output logic cpu_clk_en_o,
   output logic periph_clk_en_o,
   output logic stopped_o,
   output logic waiting_o,
   // freeze options
   input wire logic wdog_freeze_en_i,
   input wire logic periodic_freeze_en_i,
   output logic wdog_freeze_o,
   output logic periodic_freeze_o,
   // reset causes
   input wire cmpv_rst_s rst_cause_i,
   input wire logic clock_monitor_enable_i,
   output logic [VEC_W-1:0] reset_vec_o,
   // interrupt requests, enables and masks
   input wire cmpv_irq_s irq_req_i,
   input wire cmpv_irq_s irq_en_i,
   input wire logic x_mask_i,
   input wire logic i_mask_i,
   input wire logic vbr_wr_i,
   input wire logic [7:0] vbr_wdata_i,
   output logic [7:0] vector_base_register_o,
   input wire logic irq_ack_i,
   output logic irq_pend_o,
   output logic [VEC_W-1:0] irq_vec_o
);
   initial begin
      if (VEC_W != 16) $error("only 16-bit vectors are served");
   end

   ////////////////////////////////////////////////////////////////////////
   // mode latch
   logic mode_reg;
   logic mode_next;
   logic strap_done_reg;
   // only special to normal is allowed by software, never back
   assign mode_next = !strap_done_reg ? boot_mode_select_i :      // [RULE_02]
      (mode_wr_i && mode_wdata_i) ? `CMPV_MODE_NORMAL : mode_reg; // [RULE_03]
   // strap captured on the first clock after release, not under reset
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         mode_reg <= `CMPV_MODE_SPECIAL; // [RULE_19]
         strap_done_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         strap_done_reg <= 1'b1;
      end
   end
   assign mode_o = mode_reg; // [RULE_03]
   assign background_debug_module_o = (mode_reg == `CMPV_MODE_SPECIAL); // [RULE_05]
   assign fetch_internal_o = (mode_reg == `CMPV_MODE_NORMAL); // [RULE_01] [RULE_04]

   ////////////////////////////////////////////////////////////////////////
   // freeze while debug is active
   assign wdog_freeze_o = wdog_freeze_en_i && background_debug_module_o; // [RULE_11]
   assign periodic_freeze_o = periodic_freeze_en_i && background_debug_module_o; // [RULE_11]

   ////////////////////////////////////////////////////////////////////////
   // interrupt qualification
   cmpv_irq_s live;
   logic [7:0] live_v;
   logic any_unmasked;
   assign live.trap = irq_req_i.trap; // [RULE_14]
   assign live.software_interrupt = irq_req_i.software_interrupt; // [RULE_14]
   assign live.link_err = irq_req_i.link_err && !x_mask_i; // [RULE_15]
   assign live.link_ext = irq_req_i.link_ext && irq_en_i.link_ext && !i_mask_i; // [RULE_15]
   assign live.periodic = irq_req_i.periodic && irq_en_i.periodic && !i_mask_i; // [RULE_16]
   assign live.serial = irq_req_i.serial && irq_en_i.serial && !i_mask_i; // [RULE_16]
   assign live.lock = irq_req_i.lock && irq_en_i.lock && !i_mask_i; // [RULE_16]
   assign live.flash = irq_req_i.flash && irq_en_i.flash && !i_mask_i; // [RULE_16]
   assign live_v = live;
   assign any_unmasked = |live_v;

   ////////////////////////////////////////////////////////////////////////
   // power state machine
   cmpv_pwr_e pwr_reg;
   cmpv_pwr_e pwr_next;
   logic wake;
   assign wake = companion_die_interrupt_i || any_unmasked; // [RULE_07] [RULE_10]
   always_comb begin
      pwr_next = pwr_reg;
      unique case (pwr_reg)
         CMPV_RUN: begin
            if (stop_instr_i) pwr_next = CMPV_STOP; // [RULE_06]
            else if (wait_instruction_i) pwr_next = CMPV_WAIT; // [RULE_08]
         end
         CMPV_WAIT: begin
            if (wake) pwr_next = CMPV_RUN; // [RULE_10]
         end
         CMPV_STOP: begin
            if (wake) pwr_next = CMPV_RUN; // [RULE_07]
         end
         default: pwr_next = CMPV_RUN;
      endcase
   end
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) pwr_reg <= CMPV_RUN; // [RULE_07] [RULE_10]
      else pwr_reg <= pwr_next;
   end
   assign stopped_o = (pwr_reg == CMPV_STOP);
   assign waiting_o = (pwr_reg == CMPV_WAIT);
   assign cpu_clk_en_o = (pwr_reg == CMPV_RUN); // [RULE_08]
   // peripherals keep their clock in wait and gate it locally if they wish
   assign periph_clk_en_o = (pwr_reg != CMPV_STOP); // [RULE_09]

   ////////////////////////////////////////////////////////////////////////
   // vector base register
   logic [7:0] vbr_reg;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) vbr_reg <= `CMPV_VBR_RESET; // [RULE_19]
      else if (vbr_wr_i) vbr_reg <= vbr_wdata_i; // [RULE_12]
   end
   assign vector_base_register_o = vbr_reg;

   ////////////////////////////////////////////////////////////////////////
   // priority encoder; lowest index carries the highest offset
   localparam logic [7:0] OFS [8] = '{`CMPV_OFS_TRAP, `CMPV_OFS_SWI,
      `CMPV_OFS_LNK, `CMPV_OFS_LNKX, `CMPV_OFS_PER, `CMPV_OFS_SER,
      `CMPV_OFS_LOCK, `CMPV_OFS_FLASH};
   logic [7:0] win_ofs;
   always_comb begin
      win_ofs = `CMPV_OFS_SPUR; // [RULE_17]
      for (int k = 7; k >= 0; k--) begin
         if (live_v[k]) win_ofs = OFS[k]; // [RULE_21] [RULE_12]
      end
   end
   // vector latched at acknowledge so it is stable while the cpu fetches
   logic [VEC_W-1:0] irq_vec_reg;
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      // constants only here, so the reset value never depends on logic
      if (sys_rst_i) irq_vec_reg <= {`CMPV_VBR_RESET, `CMPV_OFS_SPUR}; // [RULE_19]
      else if (irq_ack_i) irq_vec_reg <= {vbr_reg, win_ofs}; // [RULE_18]
   end
   assign irq_vec_o = irq_vec_reg;
   assign irq_pend_o = any_unmasked;

   ////////////////////////////////////////////////////////////////////////
   // fixed reset vectors, sampled on the first clock after reset release
   logic [VEC_W-1:0] rvec_next;
   logic [VEC_W-1:0] rvec_reg;
   assign rvec_next = rst_cause_i.wdog ? `CMPV_VEC_WDOG :
      (rst_cause_i.osc && clock_monitor_enable_i) ? `CMPV_VEC_OSC :
      `CMPV_VEC_SYS; // [RULE_13]
   // no ram here: the array is never cleared by this block [RULE_20]
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) rvec_reg <= `CMPV_VEC_SYS; // [RULE_19]
      else if (!strap_done_reg) rvec_reg <= rvec_next; // [RULE_13]
   end
   assign reset_vec_o = rvec_reg;

   ////////////////////////////////////////////////////////////////////////
   // checks
   property p_strap;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !strap_done_reg |=> mode_o == $past(boot_mode_select_i);
   endproperty
   a_strap: assert property (p_strap) else $error("strap not captured"); // [RULE_02]
   property p_no_back;
      @(posedge mclk_i) disable iff (sys_rst_i)
      strap_done_reg && mode_o |=> mode_o;
   endproperty
   a_no_back: assert property (p_no_back) else $error("mode went back"); // [RULE_03]
   property p_bdm;
      @(posedge mclk_i) disable iff (sys_rst_i)
      background_debug_module_o == !mode_o;
   endproperty
   a_bdm: assert property (p_bdm) else $error("debug state wrong"); // [RULE_05]
   property p_stop;
      @(posedge mclk_i) disable iff (sys_rst_i)
      cpu_clk_en_o && stop_instr_i |=> stopped_o && !periph_clk_en_o;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not entered"); // [RULE_06]
   property p_wake;
      @(posedge mclk_i) disable iff (sys_rst_i)
      (stopped_o || waiting_o) && companion_die_interrupt_i |=> cpu_clk_en_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake"); // [RULE_07]
   property p_wait;
      @(posedge mclk_i) disable iff (sys_rst_i)
      cpu_clk_en_o && !stop_instr_i && wait_instruction_i
         |=> waiting_o && !cpu_clk_en_o && periph_clk_en_o;
   endproperty
   a_wait: assert property (p_wait) else $error("wait not entered"); // [RULE_08]
   property p_freeze;
      @(posedge mclk_i) disable iff (sys_rst_i)
      mode_o |-> !wdog_freeze_o && !periodic_freeze_o;
   endproperty
   a_freeze: assert property (p_freeze) else $error("freeze in normal"); // [RULE_11]
   property p_swi;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i && irq_req_i.software_interrupt && !irq_req_i.trap
         |=> irq_vec_o == {$past(vbr_reg), 8'hf6};
   endproperty
   a_swi: assert property (p_swi) else $error("swi vector wrong"); // [RULE_14]
   property p_spur;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i && !irq_pend_o |=> irq_vec_o[7:0] == 8'h80;
   endproperty
   a_spur: assert property (p_spur) else $error("spurious wrong"); // [RULE_17]
   property p_lnk;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i && x_mask_i && !(|irq_req_i[7:3]) && !irq_req_i.trap
         && !irq_req_i.software_interrupt |=> irq_vec_o[7:0] != 8'hf4;
   endproperty
   a_lnk: assert property (p_lnk) else $error("x mask ignored"); // [RULE_15]
   // mode decode and low-power clocking
   property p_fetch;
      @(posedge mclk_i) disable iff (sys_rst_i)
      fetch_internal_o == mode_o;
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch source wrong"); // [RULE_04]
   property p_mode_hold;
      @(posedge mclk_i) disable iff (sys_rst_i)
      strap_done_reg && !mode_wr_i |=> $stable(mode_o);
   endproperty
   a_mode_hold: assert property (p_mode_hold) else $error("mode moved"); // [RULE_03]
   property p_periph;
      @(posedge mclk_i) disable iff (sys_rst_i)
      waiting_o |-> periph_clk_en_o && !cpu_clk_en_o;
   endproperty
   a_periph: assert property (p_periph) else $error("wait clocks wrong"); // [RULE_09]
   property p_wait_wake;
      @(posedge mclk_i) disable iff (sys_rst_i)
      waiting_o && irq_pend_o |=> cpu_clk_en_o;
   endproperty
   a_wait_wake: assert property (p_wait_wake) else $error("wait kept"); // [RULE_10]
   property p_stop_wake;
      @(posedge mclk_i) disable iff (sys_rst_i)
      stopped_o && irq_pend_o |=> cpu_clk_en_o;
   endproperty
   a_stop_wake: assert property (p_stop_wake) else $error("stop kept"); // [RULE_07]
   // vector formation
   property p_trap;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i && irq_req_i.trap |=> irq_vec_o[7:0] == 8'hf8;
   endproperty
   a_trap: assert property (p_trap) else $error("trap vector wrong"); // [RULE_14]
   property p_vbr_hi;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i |=> irq_vec_o[15:8] == $past(vbr_reg);
   endproperty
   a_vbr_hi: assert property (p_vbr_hi) else $error("base not used"); // [RULE_12]
   property p_vbr_keep;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !vbr_wr_i |=> $stable(vector_base_register_o);
   endproperty
   a_vbr_keep: assert property (p_vbr_keep) else $error("base moved"); // [RULE_12]
   property p_ivec_even;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_vec_o[0] == 1'b0;
   endproperty
   a_ivec_even: assert property (p_ivec_even) else $error("odd vector"); // [RULE_18]
   property p_link_ext;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i && irq_req_i.link_ext && irq_en_i.link_ext && !i_mask_i
         && irq_req_i[2:0] == 3'h0 |=> irq_vec_o[7:0] == 8'hf2;
   endproperty
   a_link_ext: assert property (p_link_ext) else $error("ext vector wrong"); // [RULE_15]
   // with i set only trap, swi and an unmasked link error may win
   property p_imask;
      @(posedge mclk_i) disable iff (sys_rst_i)
      irq_ack_i && i_mask_i && !irq_req_i.trap && !irq_req_i.software_interrupt
         && !(irq_req_i.link_err && !x_mask_i) |=> irq_vec_o[7:0] == 8'h80;
   endproperty
   a_imask: assert property (p_imask) else $error("i mask ignored"); // [RULE_16]
   // reset vectors, taken once on the first edge after release
   property p_rvec_wdog;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !strap_done_reg && rst_cause_i.wdog |=> reset_vec_o == 16'hfffa;
   endproperty
   a_rvec_wdog: assert property (p_rvec_wdog) else $error("wdog vector"); // [RULE_13]
   property p_rvec_osc;
      @(posedge mclk_i) disable iff (sys_rst_i)
      !strap_done_reg && !rst_cause_i.wdog && rst_cause_i.osc
         && clock_monitor_enable_i |=> reset_vec_o == 16'hfffc;
   endproperty
   a_rvec_osc: assert property (p_rvec_osc) else $error("osc vector"); // [RULE_13]
   property p_rvec_keep;
      @(posedge mclk_i) disable iff (sys_rst_i)
      strap_done_reg |=> $stable(reset_vec_o);
   endproperty
   a_rvec_keep: assert property (p_rvec_keep) else $error("vector moved"); // [RULE_13]
endmodule // cmpv_top
`default_nettype wire

// [cmpv_cpu_model.sv]
// cpu-side model: instruction pulses and vector acknowledge
`timescale 1ns/10ps
`default_nettype none
module cmpv_cpu_model (
   // command from the bench and clock state of the block
   input wire logic [1:0] op_i,
   input wire logic cpu_clk_en_i,
   // pulses toward the block
   output logic stop_o,
   output logic wait_o,
   output logic ack_o
);
   ////////////////////////////////////////////////////////////////////////
   // decode; a halted cpu has no clock, so it can never acknowledge
   assign stop_o = (op_i == 2'h1);
   assign wait_o = (op_i == 2'h2);
   assign ack_o = (op_i == 2'h3) && cpu_clk_en_i;
endmodule // cmpv_cpu_model
`default_nettype wire

// [chip_mode_power_vectors_test.sv]
// self-checking bench for the mode, power and vector block
`timescale 1ns/10ps
`default_nettype none
module chip_mode_power_vectors_test;
   import cmpv_pkg::*;
   logic clk, rst, boot, mwr, mwd, cdi, clock_monitor_enable, xm, im, vwr, wfz, pfz, pend;
   logic mode, dbg, fi, cpuen, pen, stp, wtg, stop, wait_instruction, ack, wfe, pfe;
   logic [1:0] op;
   logic [7:0] vwd, vbr;
   logic [15:0] rvec, ivec;
   cmpv_rst_s cause;
   cmpv_irq_s req, en;
   int failures, checked;
   logic [7:0] ofs [8] = '{8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'hd8,
      8'hc6, 8'hb8};
   ////////////////////////////////////////////////////////////////////////
   // block and cpu model
   cmpv_top dut (.mclk_i(clk), .sys_rst_i(rst), .boot_mode_select_i(boot),
      .mode_wr_i(mwr), .mode_wdata_i(mwd), .mode_o(mode),
      .background_debug_module_o(dbg), .fetch_internal_o(fi),
      .stop_instr_i(stop), .wait_instruction_i(wait_instruction),
      .companion_die_interrupt_i(cdi), .cpu_clk_en_o(cpuen),
      .periph_clk_en_o(pen), .stopped_o(stp), .waiting_o(wtg),
      .wdog_freeze_en_i(wfe), .periodic_freeze_en_i(pfe),
      .wdog_freeze_o(wfz), .periodic_freeze_o(pfz), .rst_cause_i(cause),
      .clock_monitor_enable_i(clock_monitor_enable), .reset_vec_o(rvec), .irq_req_i(req),
      .irq_en_i(en), .x_mask_i(xm), .i_mask_i(im), .vbr_wr_i(vwr),
      .vbr_wdata_i(vwd), .vector_base_register_o(vbr), .irq_ack_i(ack),
      .irq_pend_o(pend), .irq_vec_o(ivec));
   cmpv_cpu_model cpu (.op_i(op), .cpu_clk_en_i(cpuen), .stop_o(stop),
      .wait_o(wait_instruction), .ack_o(ack));
   ////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      conclude();
   end
   ////////////////////////////////////////////////////////////////////////
   // shared tasks
   task automatic chk(input string n, input logic [15:0] s, e);
      checked++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // inputs move 1 ns after the edge so nothing races the sampling edge
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic pulse(input logic [1:0] o);
      op = o;
      tick(1);
      op = 2'h0;
   endtask
   // cause is held over the first edge after release, where it is taken
   task automatic boot_up(input logic b, input logic [2:0] c, input logic m);
      rst = 1'b1;
      boot = b;
      cause = c;
      clock_monitor_enable = m;
      tick(16);
      chk("vbr_rst", vbr, 16'h00ff);
      chk("ivec_rst", ivec, 16'hff80);
      rst = 1'b0;
      tick(2);
      cause = 3'h0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {rst, boot, mwr, mwd, cdi, clock_monitor_enable, xm, im, vwr, op, vwd} = '0;
      cause = '0;
      {wfe, pfe} = 2'h3;
      req = '0;
      en = '0;
      failures = 0;
      checked = 0;
      boot_up(1'b1, 3'h4, 1'b0);
      chk("mode_n", mode, 16'h1);
      chk("fetch", fi, 16'h1);
      chk("wfz_n", wfz, 16'h0);
      chk("rvec_sys", rvec, 16'hfffe);
      boot_up(1'b0, 3'h1, 1'b0);
      chk("mode_s", mode, 16'h0);
      chk("dbg", dbg, 16'h1);
      chk("wfz", wfz, 16'h1);
      chk("pfz", pfz, 16'h1);
      {wfe, pfe} = 2'h0;
      #1 chk("fz_off", {wfz, pfz}, 16'h0);
      {wfe, pfe} = 2'h3;
      chk("rvec_wdog", rvec, 16'hfffa);
      mwr = 1'b1;
      tick(1);
      chk("mode_wr0", mode, 16'h0);
      mwd = 1'b1;
      tick(1);
      mwr = 1'b0;
      chk("mode_wr1", mode, 16'h1);
      boot_up(1'b1, 3'h2, 1'b1);
      chk("rvec_osc", rvec, 16'hfffc);
      boot_up(1'b1, 3'h2, 1'b0);
      chk("rvec_nocme", rvec, 16'hfffe);
      $display("mode and reset tests done");
      // stop, refused wait, companion wake, then wait and irq wake
      pulse(2'h1);
      chk("stop", {stp, cpuen, pen}, 16'h4);
      pulse(2'h2);
      chk("stop_hold", stp, 16'h1);
      cdi = 1'b1;
      tick(1);
      cdi = 1'b0;
      chk("wake_cdi", cpuen, 16'h1);
      pulse(2'h2);
      chk("wait", {wtg, cpuen, pen}, 16'h5);
      req.periodic = 1'b1;
      en.periodic = 1'b1;
      im = 1'b1;
      tick(1);
      chk("wait_masked", wtg, 16'h1);
      im = 1'b0;
      tick(1);
      chk("wake_irq", cpuen, 16'h1);
      $display("power tests done");
      // relocated vectors, one source at a time, then all at once
      vwr = 1'b1;
      vwd = 8'h12;
      tick(1);
      vwr = 1'b0;
      chk("vbr", vbr, 16'h0012);
      en = '1;
      for (int k = 0; k < 8; k++) begin
         req = 8'h01 << k;
         pulse(2'h3);
         chk("vec", ivec, {8'h12, ofs[k]});
      end
      req = '1;
      pulse(2'h3);
      chk("vec_prio", ivec, 16'h12f8);
      req = 8'h04;
      xm = 1'b1;
      #1 chk("x_mask", pend, 16'h0);
      req = 8'h08;
      en = '0;
      #1 chk("ext_en", pend, 16'h0);
      req = 8'h20;
      en = '1;
      im = 1'b1;
      #1 chk("i_mask", pend, 16'h0);
      req = 8'h01;
      en = '0;
      #1 chk("trap_nomask", pend, 16'h1);
      req = '0;
      tick(1);
      pulse(2'h3);
      chk("spurious", ivec, 16'h1280);
      $display("vector tests done");
      conclude();
   end
endmodule // chip_mode_power_vectors_test
`default_nettype wire
